// ### design/arcr_regs.vh
// Register selects, field positions, reset values and frame sizes for the
// result and correction register group. Definitions only.
`ifndef ARCR_REGS_VH
`define ARCR_REGS_VH

// Register selects carried in the low nibble of the instruction byte
`define ARCR_SEL_RESULT      4'h0
`define ARCR_SEL_OFFSET      4'h1
`define ARCR_SEL_FULLSCALE   4'h2
`define ARCR_SEL_CONTROL     4'h3

// Instruction byte fields
`define ARCR_INSTR_READ_BIT  7
`define ARCR_INSTR_SEL_HI    3
`define ARCR_INSTR_SEL_LO    0

// Control register fields
`define ARCR_CTL_FORMAT_BIT  0
`define ARCR_CTL_UNIPOLAR_BIT 1
`define ARCR_CTL_READY_BIT   2

// Idle pin levels, bit 0 clock, bit 1 select, bit 2 data
`define ARCR_PIN_IDLE        3'h2

// Reset values
`define ARCR_OFFSET_RESET    24'h000000
`define ARCR_FULLSCALE_RESET 24'h400000
`define ARCR_CONTROL_RESET   2'h0
`define ARCR_RESULT_RESET    24'h000000

// Gain scaling: a full-scale word of 2^22 is unity gain
`define ARCR_GAIN_SHIFT      22

// Serial frame: one instruction byte then three data bytes, MSB first
`define ARCR_INSTR_BITS      6'h08
`define ARCR_FRAME_BITS      6'h20

// Signed result limits
`define ARCR_POS_LIMIT       24'h7FFFFF
`define ARCR_NEG_LIMIT       24'h800000

`endif

// ### design/arcr_result_cal_regs.v
// Result register, offset and full-scale correction registers of a
// delta-sigma converter, reached over a synchronous serial port.
// Assumes the filter delivers raw results as a one-cycle strobe on sys_clk
// and the serial clock, select and data come from outside this domain.
//
// Contract
// - Hold latest result, 24 bits, three bytes
// - Load result just before ready falls low
// - Unread result overwritten by next conversion
// - Force ready high before update unless reading
// - Format bit selects twos complement or offset
// - Unipolar bit clamps result to unipolar values
// - Offset register corrects every stored result
// - Host reads and writes offset register
// - Offset register always twos complement coded
// - Full-scale register applies gain to results
// - Host reads and writes full-scale register
// - Full-scale register always unsigned binary
// - Corrections are linear functions of registers
// - Calibration completion stores both correction words
// - Ready low means result ready, status mirrors
`include "arcr_regs.vh"

module arcr_result_cal_regs #(
	parameter DATA_W = 24
) (
	// Clock, reset, enable
	input  wire              sys_clk,
	input  wire              reset,
	input  wire              clk_en,
	// Raw conversions from the filter
	input  wire [DATA_W-1:0] raw_result,
	input  wire              raw_valid,
	// Calibration results
	input  wire              cal_done,
	input  wire [DATA_W-1:0] cal_offset,
	input  wire [DATA_W-1:0] cal_fullscale,
	// Serial port
	input  wire              serial_clk,
	input  wire              serial_cs_n,
	input  wire              serial_data_in,
	output reg               serial_data_out_pin,
	output reg               serial_data_oe,
	// Result ready
	output reg               result_ready_n
);

	localparam ST_IDLE = 3'b001;
	localparam ST_LOAD = 3'b010;
	localparam ST_SHOW = 3'b100;

	// Idle levels of the pins: clock low, select high, data low
	localparam [2:0] PIN_IDLE = `ARCR_PIN_IDLE;

	// Host pins in bit order: clock, select, data
	genvar            g;
	wire [2:0]        pin_in = {serial_data_in, serial_cs_n, serial_clk};
	wire [2:0]        pin_f;
	wire [2:0]        pin_q;
	wire              sclk_ff = pin_q[0];
	wire              cs_n_ff = pin_q[1];
	wire              sdi_ff  = pin_q[2];
	reg  [5:0]        bit_cnt_ff;
	reg  [7:0]        instr_ff;
	reg  [DATA_W-1:0] rx_ff;
	reg  [DATA_W-1:0] tx_ff;
	reg  [DATA_W-1:0] conversion_result_ff;
	reg  [DATA_W-1:0] offset_correction_ff;
	reg  [DATA_W-1:0] fullscale_correction_ff;
	reg  [1:0]        control_ff;
	reg  [DATA_W-1:0] corr_ff;
	reg  [2:0]        state_ff;

	// Filtered host clock and its edges inside a frame
	wire sclk_f   = pin_f[0];
	wire sclk_rise = sclk_f & ~sclk_ff & ~cs_n_ff;
	wire sclk_fall = ~sclk_f & sclk_ff & ~cs_n_ff;

	wire       is_read   = instr_ff[`ARCR_INSTR_READ_BIT];
	wire [3:0] reg_sel   = instr_ff[`ARCR_INSTR_SEL_HI:`ARCR_INSTR_SEL_LO];
	// Select as it stands once the eighth instruction bit is in; the read
	// word is latched on that same edge, before instr_ff has the last bit
	wire [3:0] load_sel  = {instr_ff[`ARCR_INSTR_SEL_HI-1:`ARCR_INSTR_SEL_LO], sdi_ff};
	wire       in_data   = (bit_cnt_ff >= `ARCR_INSTR_BITS);
	// A result read holds from the instruction until the select rises
	wire       rd_busy   = ~cs_n_ff & in_data & is_read &&
	                       (reg_sel == `ARCR_SEL_RESULT);
	wire       last_rise = sclk_rise && (bit_cnt_ff == `ARCR_FRAME_BITS - 6'h01);

	// Correction path: both terms are linear in the stored words
	wire signed [DATA_W:0]     diff_s = $signed({raw_result[DATA_W-1], raw_result}) -
	                                    $signed({offset_correction_ff[DATA_W-1],
	                                             offset_correction_ff});
	wire signed [2*DATA_W+1:0] prod_s = diff_s *
	                                    $signed({1'b0, fullscale_correction_ff});
	wire [2*DATA_W+1:0]        prod_u = prod_s;
	wire [DATA_W+3:0]          scaled = prod_u[2*DATA_W+1:`ARCR_GAIN_SHIFT];
	wire                       sat_hi = ~scaled[DATA_W+3] & (|scaled[DATA_W+3:DATA_W-1]);
	wire                       sat_lo = scaled[DATA_W+3] & ~(&scaled[DATA_W+3:DATA_W-1]);

	reg  [DATA_W-1:0] nxt_corr;
	reg  [DATA_W-1:0] rd_word;

	always @* begin
		if (sat_hi)
			nxt_corr = `ARCR_POS_LIMIT;
		else if (sat_lo)
			nxt_corr = `ARCR_NEG_LIMIT;
		else
			nxt_corr = scaled[DATA_W-1:0];
		if (control_ff[`ARCR_CTL_UNIPOLAR_BIT] && nxt_corr[DATA_W-1])
			nxt_corr = {DATA_W{1'b0}};
		if (control_ff[`ARCR_CTL_FORMAT_BIT])
			nxt_corr[DATA_W-1] = ~nxt_corr[DATA_W-1];
	end

	// Read mux; the ready flag is read-only in the control word
	always @* begin
		case (load_sel)
			`ARCR_SEL_RESULT:    rd_word = conversion_result_ff;
			`ARCR_SEL_OFFSET:    rd_word = offset_correction_ff;
			`ARCR_SEL_FULLSCALE: rd_word = fullscale_correction_ff;
			`ARCR_SEL_CONTROL:   rd_word = {{(DATA_W-3){1'b0}}, result_ready_n,
			                                control_ff};
			default:             rd_word = {DATA_W{1'b0}};
		endcase
	end

	// Input synchronisers; a level counts once stages two and three agree,
	// so a single sample caught mid-transition never makes a false edge
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_pin
			reg [2:0] sync_ff;
			reg       hold_ff;
			assign pin_f[g] = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : hold_ff;
			assign pin_q[g] = hold_ff;
			always @(posedge sys_clk or posedge reset) begin
				if (reset) begin
					sync_ff <= {3{PIN_IDLE[g]}};
					hold_ff <= PIN_IDLE[g];
				end else if (clk_en) begin
					sync_ff <= {sync_ff[1:0], pin_in[g]};
					hold_ff <= pin_f[g];
				end
			end
		end
	endgenerate

	// Bit counter; clocks after the last bit are ignored
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bit_cnt_ff <= 6'h00;
		end else if (clk_en) begin
			if (cs_n_ff)
				bit_cnt_ff <= 6'h00;
			else if (sclk_rise && bit_cnt_ff != `ARCR_FRAME_BITS)
				bit_cnt_ff <= bit_cnt_ff + 6'h01;
		end
	end

	// Instruction then write data shift in on rising edges, MSB first
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			instr_ff <= 8'h00;
			rx_ff    <= {DATA_W{1'b0}};
		end else if (clk_en) begin
			if (sclk_rise && bit_cnt_ff != `ARCR_FRAME_BITS) begin
				if (in_data)
					rx_ff <= {rx_ff[DATA_W-2:0], sdi_ff};
				else
					instr_ff <= {instr_ff[6:0], sdi_ff};
			end
		end
	end

	// Read word latched with the last instruction bit, then shifted out;
	// latching once keeps a read coherent even if a register changes later
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_ff <= {DATA_W{1'b0}};
		end else if (clk_en) begin
			if (sclk_rise && bit_cnt_ff == `ARCR_INSTR_BITS - 6'h01)
				tx_ff <= rd_word;
			else if (sclk_fall && in_data && is_read && bit_cnt_ff != `ARCR_FRAME_BITS)
				tx_ff <= {tx_ff[DATA_W-2:0], 1'b0};
		end
	end

	// Drive only between instruction end and frame end
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			serial_data_out_pin <= 1'b0;
			serial_data_oe      <= 1'b0;
		end else if (clk_en) begin
			if (cs_n_ff) begin
				serial_data_oe <= 1'b0;
			end else if (sclk_fall && in_data && is_read &&
			             bit_cnt_ff != `ARCR_FRAME_BITS) begin
				serial_data_out_pin <= tx_ff[DATA_W-1];
				serial_data_oe      <= 1'b1;
			end else if (sclk_fall && bit_cnt_ff == `ARCR_FRAME_BITS) begin
				serial_data_oe <= 1'b0;
			end
		end
	end

	// Offset word; calibration wins over a host write in the same cycle
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			offset_correction_ff <= `ARCR_OFFSET_RESET;
		end else if (clk_en) begin
			if (cal_done)
				offset_correction_ff <= cal_offset;
			else if (last_rise && !is_read && reg_sel == `ARCR_SEL_OFFSET)
				offset_correction_ff <= {rx_ff[DATA_W-2:0], sdi_ff};
		end
	end

	// Full-scale word, same priority as the offset word
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			fullscale_correction_ff <= `ARCR_FULLSCALE_RESET;
		end else if (clk_en) begin
			if (cal_done)
				fullscale_correction_ff <= cal_fullscale;
			else if (last_rise && !is_read && reg_sel == `ARCR_SEL_FULLSCALE)
				fullscale_correction_ff <= {rx_ff[DATA_W-2:0], sdi_ff};
		end
	end

	// Format and unipolar bits; the ready bit of this word is read-only
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			control_ff <= `ARCR_CONTROL_RESET;
		end else if (clk_en) begin
			if (last_rise && !is_read && reg_sel == `ARCR_SEL_CONTROL)
				control_ff <= {rx_ff[0], sdi_ff};
		end
	end

	// Corrected word is captured at every conversion; a later one replaces
	// a pending one and the unread word is lost
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			corr_ff <= {DATA_W{1'b0}};
		end else if (clk_en) begin
			if (raw_valid)
				corr_ff <= nxt_corr;
		end
	end

	// Result update sequence
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_ff <= ST_IDLE;
		end else if (clk_en) begin
			case (state_ff)
				ST_IDLE: begin
					if (raw_valid)
						state_ff <= ST_LOAD;
				end
				ST_LOAD: begin
					// Held off while a result read runs so all bytes match
					if (!rd_busy && !raw_valid)
						state_ff <= ST_SHOW;
				end
				ST_SHOW: begin
					if (raw_valid)
						state_ff <= ST_LOAD;
					else
						state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Result register loads one cycle before ready falls
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			conversion_result_ff <= `ARCR_RESULT_RESET;
		end else if (clk_en) begin
			if (state_ff == ST_LOAD && !rd_busy && !raw_valid)
				conversion_result_ff <= corr_ff;
		end
	end

	// Ready output; low two edges after a conversion, and a finished
	// result read counts as consumed so the host sees no stale flag
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			result_ready_n <= 1'b1;
		end else if (clk_en) begin
			if (state_ff == ST_SHOW && !raw_valid)
				result_ready_n <= 1'b0;
			else if (raw_valid && !rd_busy)
				result_ready_n <= 1'b1;
			else if (rd_busy && last_rise)
				result_ready_n <= 1'b1;
		end
	end

endmodule

// ### verification/arcr_chk_properties.sv
// Checks on the ready output and the data-line enable.
// Assumes it is bound to the register group top and sees only its ports.
module arcr_chk #(parameter DATA_W = 24) (
	// Clock and reset
	input wire              sys_clk,
	input wire              reset,
	input wire              clk_en,
	// Filter and calibration side
	input wire [DATA_W-1:0] raw_result,
	input wire              raw_valid,
	input wire              cal_done,
	input wire [DATA_W-1:0] cal_offset,
	input wire [DATA_W-1:0] cal_fullscale,
	// Serial port and ready
	input wire              serial_clk,
	input wire              serial_cs_n,
	input wire              serial_data_in,
	input wire              serial_data_out_pin,
	input wire              serial_data_oe,
	input wire              result_ready_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Port idle long enough that no result read can still be finishing
	sequence s_quiet; serial_cs_n[*8]; endsequence
	sequence s_load; s_quiet ##0 raw_valid ##1 !raw_valid[*2]; endsequence
	chk_ready_rise: assert property (s_quiet ##0 raw_valid |=> result_ready_n)
		else $error("ready not raised");
	chk_ready_fall: assert property (s_load |-> ##[0:1] !result_ready_n)
		else $error("ready not lowered");
	chk_fall_cause: assert property (s_quiet ##0 $fell(result_ready_n)
		|-> $past(raw_valid, 2) || $past(raw_valid, 3)) else $error("ready fell alone");
	chk_ready_hold: assert property (s_quiet ##0 !result_ready_n && !raw_valid
		|=> !result_ready_n) else $error("ready dropped");
	chk_idle_high: assert property ((serial_cs_n && !raw_valid)[*8]
		##0 result_ready_n |=> result_ready_n) else $error("ready without result");
	chk_reset_idle: assert property ($fell(reset)
		|-> result_ready_n && !serial_data_oe) else $error("bad reset state");
	chk_oe_release: assert property (serial_cs_n[*5] |-> !serial_data_oe)
		else $error("line driven idle");
	chk_oe_frame: assert property ($rose(serial_data_oe)
		|-> !serial_cs_n ##1 serial_data_oe[*3]) else $error("bad enable");
endmodule
bind arcr_result_cal_regs arcr_chk #(.DATA_W(DATA_W)) i_arcr_chk (.*);

// ### verification/arcr_host.sv
// Host model: 32-bit serial frames, clock still outside frames.
// Assumes the device oversamples the pins with a faster clock.
module arcr_host (
	// Serial pins
	output reg  serial_clk,
	output reg  serial_cs_n,
	output reg  serial_data_in,
	input  wire serial_data_out_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		serial_clk = 1'h0;
		serial_cs_n = 1'h1;
		serial_data_in = 1'h0;
	end
	// Frames shorter than 32 bits abort; 200 ns bit period
	task frame(input [7:0] ins, input [23:0] wd, input integer n, output [23:0] rd);
		integer    i;
		reg [31:0] word;
		begin
			word = {ins, wd};
			rd = 24'h0;
			serial_cs_n = 1'h0;
			#100;
			for (i = 0; i < n; i = i + 1) begin
				serial_data_in = word[31 - i];
				#100;
				serial_clk = 1'h1;
				#100;
				// Sample just before the fall: the bit has settled for a whole half period
				if (i > 7)
					rd = {rd[22:0], serial_data_out_pin};
				serial_clk = 1'h0;
			end
			#100;
			serial_cs_n = 1'h1;
			// Released line must not keep showing the last bit
			serial_data_in = ~serial_data_in;
			#400;
		end
	endtask
endmodule

// ### verification/test_arcr_result_cal_regs.sv
// Bench: random corrections and results read back through a host model.
// Assumes a 40 MHz sys_clk and a 200 ns serial clock.
module test_arcr_result_cal_regs;
	timeunit 1ns;
	timeprecision 100ps;
	reg        sys_clk = 1'h0;
	reg        reset = 1'h1;
	reg        raw_valid = 1'h0;
	reg        cal_done = 1'h0;
	reg [23:0] raw_result = 24'h0;
	reg [23:0] cal_offset = 24'h0;
	reg [23:0] cal_fullscale = 24'h0;
	reg [23:0] off, fs, rd, r0;
	reg [1:0]  ctl;
	wire       sclk, cs_n, sdi, sdo, oe, rdy_n;
	integer    seed = 32'h31A8;
	integer    bad_count = 0;
	integer    tests_run = 0;
	integer    k;
	always #12.5 sys_clk = ~sys_clk;
	arcr_result_cal_regs i_arcr_result_cal_regs (.sys_clk(sys_clk), .reset(reset), .clk_en(1'h1),
		.raw_result(raw_result), .raw_valid(raw_valid), .cal_done(cal_done), .cal_offset(cal_offset),
		.cal_fullscale(cal_fullscale), .serial_clk(sclk), .serial_cs_n(cs_n), .serial_data_in(sdi),
		.serial_data_out_pin(sdo), .serial_data_oe(oe), .result_ready_n(rdy_n));
	arcr_host i_arcr_host (.serial_clk(sclk), .serial_cs_n(cs_n), .serial_data_in(sdi),
		.serial_data_out_pin(sdo));
	function [23:0] exp_res(input [23:0] r, input [23:0] o, input [23:0] f, input [1:0] c);
		reg signed [63:0] v;
		begin
			v = (($signed({{40{r[23]}}, r}) - $signed({{40{o[23]}}, o})) * $signed({40'h0, f})) >>> 22;
			if (v > 64'sh7FFFFF) v = 64'sh7FFFFF;
			if (v < -64'sh800000) v = -64'sh800000;
			if (c[1] && v < 0) v = 0;
			exp_res = v[23:0] ^ {c[0], 23'h0};
		end
	endfunction
	task chk(input [23:0] seen, input [23:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task xfer(input [7:0] ins, input [23:0] wd);
		begin
			@(posedge sys_clk) #2;
			i_arcr_host.frame(ins, wd, 32, rd);
		end
	endtask
	task conv(input [23:0] r);
		begin
			@(posedge sys_clk) #2;
			raw_result = r;
			raw_valid = 1'h1;
			@(posedge sys_clk) #2;
			raw_valid = 1'h0;
			repeat (4) @(posedge sys_clk);
		end
	endtask
	task print_verdict;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, bad_count);
			if (bad_count == 0 && tests_run > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		#2000000;
		bad_count = bad_count + 1;
		print_verdict;
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		#2 reset = 1'h0;
		chk(rdy_n, 1'h1);
		xfer(8'h81, 24'h0);
		chk(rd, 24'h0);
		xfer(8'h82, 24'h0);
		chk(rd, 24'h400000);
		// Each format and unipolar mode twice, hitting saturation too
		for (k = 0; k < 8; k = k + 1) begin
			off = $random(seed);
			fs = $random(seed);
			r0 = $random(seed);
			ctl = k;
			xfer(8'h01, off);
			xfer(8'h02, fs);
			xfer(8'h03, {22'h0, ctl});
			xfer(8'h81, 24'h0);
			chk(rd, off);
			xfer(8'h82, 24'h0);
			chk(rd, fs);
			conv($random(seed));
			conv(r0);
			chk(rdy_n, 1'h0);
			xfer(8'h83, 24'h0);
			chk(rd, {21'h0, 1'h0, ctl});
			xfer(8'h00, 24'hFFFFFF);
			xfer(8'h80, 24'h0);
			chk(rd, exp_res(r0, off, fs, ctl));
			chk(rdy_n, 1'h1);
		end
		// A result arriving mid-read must wait for the frame to end
		conv(r0);
		fork
			xfer(8'h80, 24'h0);
			#3000 conv(24'h654321);
		join
		chk(rd, exp_res(r0, off, fs, ctl));
		chk(rdy_n, 1'h0);
		xfer(8'h80, 24'h0);
		chk(rd, exp_res(24'h654321, off, fs, ctl));
		@(posedge sys_clk) #2;
		cal_offset = $random(seed);
		cal_fullscale = $random(seed);
		cal_done = 1'h1;
		@(posedge sys_clk) #2;
		cal_done = 1'h0;
		@(posedge sys_clk) #2;
		i_arcr_host.frame(8'h01, 24'h0, 20, rd);
		xfer(8'h81, 24'h0);
		chk(rd, cal_offset);
		xfer(8'h82, 24'h0);
		chk(rd, cal_fullscale);
		print_verdict;
	end
endmodule
